// ### src/pfbo_pkg.sv
// Purpose: shared constants for the fault B override block
// Assumes: registers reached by index on a plain strobe port
// Notes:   key values and offsets are local choices
package pfbo_pkg;
   localparam int          PFBO_AW           = 3;
   localparam int          PFBO_DW           = 16;
   // register indices
   localparam logic [2:0]  PFBO_REG_CTRL     = 3'h0;
   localparam logic [2:0]  PFBO_REG_KEY      = 3'h1;
   localparam logic [2:0]  PFBO_REG_STATUS   = 3'h2;
   localparam logic [2:0]  PFBO_REG_MASK     = 3'h3;
   localparam logic [2:0]  PFBO_REG_FAULT    = 3'h4;
   // control field layout
   localparam int          PFBO_OV_LSB       = 8;
   localparam int          PFBO_MODE_BIT     = 7;
   localparam logic [15:0] PFBO_CTRL_MASK    = 16'h3F87;
   // reset values
   localparam logic [5:0]  PFBO_OV_RESET     = 6'h00;
   localparam logic        PFBO_MODE_RESET   = 1'h0;
   localparam logic [2:0]  PFBO_EN_RESET     = 3'h7;
   localparam logic [2:0]  PFBO_STATUS_RESET = 3'h0;
   localparam logic [2:0]  PFBO_MASK_RESET   = 3'h0;
   // unlock sequence, values arbitrary
   localparam logic [15:0] PFBO_KEY_FIRST    = 16'h4D4D;
   localparam logic [15:0] PFBO_KEY_SECOND   = 16'hB2B2;
   // status bits
   localparam int          PFBO_ST_FAULT     = 0;
   localparam int          PFBO_ST_REJECT    = 1;
   localparam int          PFBO_ST_RELEASE   = 2;
   // fault register bits
   localparam int          PFBO_FLT_CLEAR    = 0;
   localparam int          PFBO_FLT_ENGAGED  = 1;
   localparam int          PFBO_FLT_UNLOCKED = 2;

   typedef enum logic [1:0] {
      PFBO_KEY_IDLE,
      PFBO_KEY_HALF,
      PFBO_KEY_OPEN
   } pfbo_key_e;
endpackage : pfbo_pkg

// ### src/pfbo_pair.sv
// Purpose: one high/low output pin pair with fault override
// Assumes: inputs synchronous to clk
// Notes:   outputs registered, one cycle after inputs
`timescale 1ns/10ps
`default_nettype none
module pfbo_pair
   import pfbo_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic enable,
   input  wire logic engaged,
   input  wire logic ov_high,
   input  wire logic ov_low,
   input  wire logic pwm_high,
   input  wire logic pwm_low,
   output var  logic out_high,
   output var  logic out_low
);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_high <= 1'h0;
         out_low  <= 1'h0;
      end else if (enable && engaged) begin
         out_high <= ov_high;
         out_low  <= ov_low;
      end else begin
         out_high <= pwm_high;
         out_low  <= pwm_low;
      end
   end
endmodule : pfbo_pair
`default_nettype wire

// ### src/pfbo_top.sv
// Purpose: fault B override control for three PWM pin pairs
// Assumes: fault_b, period_start and pwm inputs synchronous to clk
// Notes:   pins active high; polarity handled downstream
// How it works
// - six override bits set forced pin levels
// - cycle mode overrides until a period start with no fault
// - latch mode holds overrides until cleared
// - enable bit three routes pair three
// - enable bit two routes pair two
// - enable bit one routes pair one
// - locked control writes need key sequence
// - unlocked control writes always accepted
// - enable bits reset to one
// - unimplemented control bits read zero
`timescale 1ns/10ps
`default_nettype none
module pfbo_top
   import pfbo_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [PFBO_AW-1:0] addr,
   input  wire logic [PFBO_DW-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output var  logic [PFBO_DW-1:0] rdata,
   input  wire logic              fault_b,
   input  wire logic              period_start,
   input  wire logic              config_write_lock,
   input  wire logic [2:0]        pwm_high_in,
   input  wire logic [2:0]        pwm_low_in,
   output logic      [2:0]        pwm_high_out,
   output logic      [2:0]        pwm_low_out,
   output var  logic              irq
);
   logic [5:0] fault_b_override_values;
   logic       fault_b_cycle_mode;
   logic       fault_b_pair3_enable;
   logic       fault_b_pair2_enable;
   logic       fault_b_pair1_enable;
   logic [2:0] pair_enable;
   pfbo_key_e  key_state;
   logic       latched;
   logic       cbc_active;
   logic       fault_prev;
   logic [2:0] status;
   logic [2:0] mask;
   logic       engaged;
   logic       ctrl_wr;
   logic       ctrl_ok;
   logic       clear_req;
   logic       fault_rise;
   logic       release_evt;
   logic       next_latched;
   logic       next_cbc;
   logic [15:0] ctrl_read;

   assign pair_enable = {fault_b_pair3_enable, fault_b_pair2_enable, fault_b_pair1_enable};
   assign ctrl_wr     = wr && (addr == PFBO_REG_CTRL);
   assign ctrl_ok     = ctrl_wr && (!config_write_lock || key_state == PFBO_KEY_OPEN);
   assign clear_req   = wr && (addr == PFBO_REG_FAULT) && wdata[PFBO_FLT_CLEAR];
   assign fault_rise  = fault_b && !fault_prev;
   assign ctrl_read   = {2'h0, fault_b_override_values, fault_b_cycle_mode, 4'h0, pair_enable};

   // override held state for each mode
   always_comb begin
      next_latched = latched;
      next_cbc     = cbc_active;
      if (clear_req) begin
         next_latched = 1'h0;
      end
      if (fault_b && !fault_b_cycle_mode) begin
         next_latched = 1'h1;
      end
      if (period_start && !fault_b) begin
         next_cbc = 1'h0;
      end
      if (fault_b && fault_b_cycle_mode) begin
         next_cbc = 1'h1;
      end
      if (!fault_b_cycle_mode) begin
         next_cbc = 1'h0;
      end
   end

   assign engaged     = fault_b_cycle_mode ? (cbc_active || fault_b) : (latched || fault_b);
   assign release_evt = (latched && !next_latched) || (cbc_active && !next_cbc && fault_b_cycle_mode);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         latched    <= 1'h0;
         cbc_active <= 1'h0;
         fault_prev <= 1'h0;
      end else begin
         latched    <= next_latched;
         cbc_active <= next_cbc;
         fault_prev <= fault_b;
      end
   end

   // control register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fault_b_override_values <= PFBO_OV_RESET;
         fault_b_cycle_mode      <= PFBO_MODE_RESET;
         fault_b_pair3_enable    <= PFBO_EN_RESET[2];
         fault_b_pair2_enable    <= PFBO_EN_RESET[1];
         fault_b_pair1_enable    <= PFBO_EN_RESET[0];
      end else if (ctrl_ok) begin
         fault_b_override_values <= wdata[PFBO_OV_LSB +: 6];
         fault_b_cycle_mode      <= wdata[PFBO_MODE_BIT];
         fault_b_pair3_enable    <= wdata[2];
         fault_b_pair2_enable    <= wdata[1];
         fault_b_pair1_enable    <= wdata[0];
      end
   end

   // unlock key sequence
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         key_state <= PFBO_KEY_IDLE;
      end else if (wr && addr == PFBO_REG_KEY) begin
         case (key_state)
            PFBO_KEY_IDLE: begin
               key_state <= (wdata == PFBO_KEY_FIRST) ? PFBO_KEY_HALF : PFBO_KEY_IDLE;
            end
            PFBO_KEY_HALF: begin
               key_state <= (wdata == PFBO_KEY_SECOND) ? PFBO_KEY_OPEN : PFBO_KEY_IDLE;
            end
            default: begin
               key_state <= (wdata == PFBO_KEY_FIRST) ? PFBO_KEY_HALF : PFBO_KEY_IDLE;
            end
         endcase
      end else if (ctrl_wr) begin
         key_state <= PFBO_KEY_IDLE; // one control write per unlock
      end
   end

   // sticky status, set wins over read clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= PFBO_STATUS_RESET;
      end else begin
         status <= ((rd && addr == PFBO_REG_STATUS) ? 3'h0 : status)
                   | {release_evt, ctrl_wr && !ctrl_ok, fault_rise};
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mask <= PFBO_MASK_RESET;
      end else if (wr && addr == PFBO_REG_MASK) begin
         mask <= wdata[2:0];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'h0;
      end else begin
         irq <= |(status & mask);
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         case (addr)
            PFBO_REG_CTRL:   rdata <= ctrl_read;
            PFBO_REG_STATUS: rdata <= {13'h0000, status};
            PFBO_REG_MASK:   rdata <= {13'h0000, mask};
            PFBO_REG_FAULT:  rdata <= {13'h0000, key_state == PFBO_KEY_OPEN, engaged, fault_b};
            default:         rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   // pairs: high override is odd bit, low is even bit
   for (genvar k = 0; k < 3; k++) begin : g_pair
      pfbo_pair u_pair (
         .clk      (clk),
         .reset    (reset),
         .enable   (pair_enable[k]),
         .engaged  (engaged),
         .ov_high  (fault_b_override_values[2*k+1]),
         .ov_low   (fault_b_override_values[2*k]),
         .pwm_high (pwm_high_in[k]),
         .pwm_low  (pwm_low_in[k]),
         .out_high (pwm_high_out[k]),
         .out_low  (pwm_low_out[k])
      );
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   chk_override_value: assert property (
      pair_enable[0] && engaged |=> pwm_high_out[0] == $past(fault_b_override_values[1])
                                    && pwm_low_out[0] == $past(fault_b_override_values[0]))
      else $error("pair one not forced to override levels");

   chk_cbc_hold: assert property (
      fault_b_cycle_mode && fault_b && !ctrl_wr |=> cbc_active && engaged)
      else $error("cycle mode fault not held");

   chk_latch_hold: assert property (
      latched && !clear_req && !fault_b_cycle_mode && !ctrl_wr |=> latched)
      else $error("latched fault dropped without clear");

   chk_pair3_free: assert property (
      !pair_enable[2] |=> pwm_high_out[2] == $past(pwm_high_in[2]) && pwm_low_out[2] == $past(pwm_low_in[2]))
      else $error("pair three touched while disabled");

   chk_pair2_free: assert property (
      !pair_enable[1] |=> pwm_high_out[1] == $past(pwm_high_in[1]) && pwm_low_out[1] == $past(pwm_low_in[1]))
      else $error("pair two touched while disabled");

   chk_pair1_free: assert property (
      !pair_enable[0] |=> pwm_high_out[0] == $past(pwm_high_in[0]) && pwm_low_out[0] == $past(pwm_low_in[0]))
      else $error("pair one touched while disabled");

   chk_locked_write: assert property (
      ctrl_wr && config_write_lock && key_state != PFBO_KEY_OPEN |=> $stable(ctrl_read) && status[PFBO_ST_REJECT])
      else $error("locked control write was taken");

   chk_open_write: assert property (
      ctrl_wr && !config_write_lock |=> ctrl_read == ($past(wdata) & PFBO_CTRL_MASK))
      else $error("unlocked control write lost");

   chk_reserved_zero: assert property (
      rd && addr == PFBO_REG_CTRL |=> (rdata & ~PFBO_CTRL_MASK) == 16'h0000)
      else $error("reserved control bits read nonzero");

   chk_cbc_release: assert property (
      fault_b_cycle_mode && cbc_active && period_start && !fault_b && !ctrl_wr |=> !cbc_active)
      else $error("cycle mode override not released");

   cov_latched: cover property (fault_b && !fault_b_cycle_mode ##1 latched ##[1:20] clear_req);
   cov_cbc: cover property (cbc_active && period_start && !fault_b ##1 !cbc_active);
   cov_unlock: cover property (config_write_lock && ctrl_ok);
   cov_irq: cover property ($rose(irq));
   cov_release: cover property (status[PFBO_ST_RELEASE] && mask[PFBO_ST_RELEASE]);

   // reset values and pair forcing
   chk_reset_enables: assert property (
      $fell(reset) |-> pair_enable == PFBO_EN_RESET)
      else $error("pair enables not set after reset");

   chk_pair2_override: assert property (
      pair_enable[1] && engaged |=> pwm_high_out[1] == $past(fault_b_override_values[3])
                                    && pwm_low_out[1] == $past(fault_b_override_values[2]))
      else $error("pair two not forced to override levels");

   chk_pair3_override: assert property (
      pair_enable[2] && engaged |=> pwm_high_out[2] == $past(fault_b_override_values[5])
                                    && pwm_low_out[2] == $past(fault_b_override_values[4]))
      else $error("pair three not forced to override levels");

   chk_engaged_fault: assert property (
      fault_b |-> engaged)
      else $error("fault input high but override idle");

   // latch and cycle mode state
   chk_latch_set: assert property (
      fault_b && !fault_b_cycle_mode |=> latched)
      else $error("latch mode fault not latched");

   chk_latch_clear: assert property (
      latched && clear_req && !fault_b && !fault_b_cycle_mode |=> !latched)
      else $error("latch not cleared by clear write");

   chk_mode_drop: assert property (
      !fault_b_cycle_mode |=> !cbc_active)
      else $error("cycle state kept in latch mode");

   chk_cbc_engaged: assert property (
      fault_b_cycle_mode && cbc_active |-> engaged)
      else $error("cycle mode hold without override");

   chk_cbc_keep: assert property (
      fault_b_cycle_mode && cbc_active && !period_start && !ctrl_wr |=> cbc_active)
      else $error("cycle mode override dropped mid period");

   // key sequence and write protection
   chk_key_consumed: assert property (
      ctrl_wr |=> key_state == PFBO_KEY_IDLE)
      else $error("unlock not consumed by control write");

   chk_key_open: assert property (
      wr && addr == PFBO_REG_KEY && key_state == PFBO_KEY_HALF && wdata == PFBO_KEY_SECOND
      |=> key_state == PFBO_KEY_OPEN)
      else $error("correct key sequence did not unlock");

   chk_key_wrong: assert property (
      wr && addr == PFBO_REG_KEY && wdata != PFBO_KEY_FIRST && wdata != PFBO_KEY_SECOND
      |=> key_state == PFBO_KEY_IDLE)
      else $error("wrong key did not reset sequence");

   chk_unlocked_ok: assert property (
      ctrl_wr && !config_write_lock |-> ctrl_ok)
      else $error("unlocked control write refused");

   chk_reject_flag: assert property (
      ctrl_wr && !ctrl_ok |=> status[PFBO_ST_REJECT])
      else $error("refused write not flagged");

   chk_reserved_ctrl: assert property (
      (ctrl_read & ~PFBO_CTRL_MASK) == 16'h0000)
      else $error("reserved control bits set");

   // status, mask, interrupt and read port
   chk_fault_flag: assert property (
      fault_b && !fault_prev |=> status[PFBO_ST_FAULT])
      else $error("fault edge not flagged");

   chk_release_flag: assert property (
      release_evt |=> status[PFBO_ST_RELEASE])
      else $error("override release not flagged");

   chk_status_clear: assert property (
      rd && addr == PFBO_REG_STATUS && !wr && !fault_rise && !release_evt |=> status == 3'h0)
      else $error("status not cleared by read");

   chk_mask_write: assert property (
      wr && addr == PFBO_REG_MASK |=> mask == $past(wdata[2:0]))
      else $error("mask write lost");

   chk_irq_level: assert property (
      1'b1 |=> irq == $past(|(status & mask)))
      else $error("interrupt level wrong");

   chk_rdata_idle: assert property (
      !rd |=> rdata == 16'h0000)
      else $error("read data not zero outside read");
endmodule : pfbo_top
`default_nettype wire

// ### tb/pfbo_partner.sv
// Purpose: fault source and gate driver stand-in
// Assumes: one clock shared with the block
// Notes:   pwm levels change every cycle, period is short
`timescale 1ns/10ps
`default_nettype none
module pfbo_partner #(
   parameter int PERIOD = 8
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       fault_req,
   output var  logic       fault_b,
   output var  logic       period_start,
   output var  logic [2:0] pwm_high,
   output var  logic [2:0] pwm_low
);
   int cnt;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= 0;
         fault_b <= 1'b0;
         period_start <= 1'b0;
         pwm_high <= 3'h0;
         pwm_low <= 3'h7;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         period_start <= (cnt == PERIOD - 1);
         fault_b <= fault_req;
         pwm_high <= pwm_high + 3'h3;
         pwm_low <= ~pwm_high;
      end
   end
endmodule : pfbo_partner
`default_nettype wire

// ### tb/pfbo_top_tb.sv
// Purpose: self-checking bench for the fault B override block
// Assumes: pins active high, outputs one cycle after inputs
// Notes:   pin model runs every cycle beside the register tests
`timescale 1ns/10ps
`default_nettype none
module pfbo_top_tb
   import pfbo_pkg::*;
;
   logic        clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, lock = 1'b0, fault_req = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [15:0] wdata = 16'h0000, rdata, v, m_ctrl;
   logic        fault_b, period_start, irq;
   logic [2:0]  ph, pl, oh, ol, e_h, e_l;
   int          failures = 0, compares = 0, m_lat, m_key, chk_on, lim;

   always #10 clk = ~clk;

   pfbo_partner #(.PERIOD(8)) partner (.clk(clk), .reset(reset), .fault_req(fault_req),
      .fault_b(fault_b), .period_start(period_start), .pwm_high(ph), .pwm_low(pl));
   pfbo_top uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .fault_b(fault_b), .period_start(period_start), .config_write_lock(lock),
      .pwm_high_in(ph), .pwm_low_in(pl), .pwm_high_out(oh), .pwm_low_out(ol), .irq(irq));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // pin and register model, sampled at the same edges as the block
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         m_ctrl = 16'h0007;
         m_lat = 0;
         m_key = 0;
         chk_on = 0;
      end else begin
         if (chk_on != 0) begin
            check("pins_high", {13'h0000, oh}, {13'h0000, e_h});
            check("pins_low", {13'h0000, ol}, {13'h0000, e_l});
         end
         for (int k = 0; k < 3; k++) begin
            e_h[k] = (m_ctrl[k] && (fault_b || m_lat != 0)) ? m_ctrl[9 + 2 * k] : ph[k];
            e_l[k] = (m_ctrl[k] && (fault_b || m_lat != 0)) ? m_ctrl[8 + 2 * k] : pl[k];
         end
         chk_on = 1;
         if (m_ctrl[PFBO_MODE_BIT])
            m_lat = (fault_b || (m_lat != 0 && !period_start)) ? 1 : 0;
         else
            m_lat = (fault_b || (m_lat != 0 && !(wr && addr == PFBO_REG_FAULT && wdata[0]))) ? 1 : 0;
         if (wr && addr == PFBO_REG_CTRL) begin
            if (!lock || m_key == 2) m_ctrl = wdata & PFBO_CTRL_MASK;
            m_key = 0;
         end
         if (wr && addr == PFBO_REG_KEY)
            m_key = (m_key == 1) ? ((wdata == PFBO_KEY_SECOND) ? 2 : 0) : ((wdata == PFBO_KEY_FIRST) ? 1 : 0);
      end
   end

   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_reg

   task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask : rd_reg

   task automatic final_report;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   initial begin
      void'($urandom(32'h95D9B48B));
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      rd_reg(PFBO_REG_CTRL, v); check("ctrl_reset", v, 16'h0007);
      wr_reg(PFBO_REG_CTRL, 16'hFFFF);
      rd_reg(PFBO_REG_CTRL, v); check("ctrl_open", v, 16'h3F87);
      rd_reg(3'h5, v); check("unmapped", v, 16'h0000);
      lock <= 1'b1;
      wr_reg(PFBO_REG_CTRL, 16'h0000);
      rd_reg(PFBO_REG_CTRL, v); check("ctrl_locked", v, 16'h3F87);
      rd_reg(PFBO_REG_STATUS, v); check("reject_flag", {15'h0000, v[1]}, 16'h0001);
      wr_reg(PFBO_REG_KEY, PFBO_KEY_FIRST);
      wr_reg(PFBO_REG_KEY, PFBO_KEY_SECOND);
      wr_reg(PFBO_REG_CTRL, 16'h0007);
      rd_reg(PFBO_REG_CTRL, v); check("ctrl_keyed", v, 16'h0007);
      wr_reg(PFBO_REG_CTRL, 16'h0000);
      rd_reg(PFBO_REG_CTRL, v); check("ctrl_relocked", v, 16'h0007);
      // a repeated first key breaks the sequence
      wr_reg(PFBO_REG_KEY, PFBO_KEY_FIRST);
      wr_reg(PFBO_REG_KEY, PFBO_KEY_FIRST);
      wr_reg(PFBO_REG_KEY, PFBO_KEY_SECOND);
      wr_reg(PFBO_REG_CTRL, 16'h0000);
      rd_reg(PFBO_REG_CTRL, v); check("ctrl_badkey", v, 16'h0007);
      lock <= 1'b0;
      // every enable pattern in both modes, random override levels
      for (int i = 0; i < 16; i++) begin
         wr_reg(PFBO_REG_CTRL, {2'b00, 6'($urandom), i[3], 4'h0, i[2:0]});
         fault_req <= 1'b1;
         repeat (3) @(posedge clk);
         fault_req <= 1'b0;
         repeat (12) @(posedge clk);
         rd_reg(PFBO_REG_FAULT, v); check("engaged", {15'h0000, v[1]}, {15'h0000, ~i[3]});
         wr_reg(PFBO_REG_FAULT, 16'h0001);
         repeat (2) @(posedge clk);
      end
      rd_reg(PFBO_REG_STATUS, v);
      wr_reg(PFBO_REG_MASK, 16'h0001);
      check("irq_idle", {15'h0000, irq}, 16'h0000);
      fault_req <= 1'b1;
      lim = 0;
      @(posedge clk);
      while (irq !== 1'b1 && lim < 10) begin
         @(posedge clk);
         lim++;
      end
      fault_req <= 1'b0;
      check("irq_raise", {15'h0000, irq}, 16'h0001);
      rd_reg(PFBO_REG_STATUS, v); check("status_fault", {15'h0000, v[0]}, 16'h0001);
      repeat (2) @(posedge clk);
      check("irq_clear", {15'h0000, irq}, 16'h0000);
      wr_reg(PFBO_REG_MASK, 16'h0000);
      fault_req <= 1'b1;
      repeat (4) @(posedge clk);
      check("irq_masked", {15'h0000, irq}, 16'h0000);
      fault_req <= 1'b0;
      repeat (4) @(posedge clk);
      final_report();
   end
endmodule : pfbo_top_tb
`default_nettype wire
